// file: hw/scp_device.sv
// synthesizer control: serial register bank, power gating, output selection
`timescale 1ns/1ns
module scp_device
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    // serial link
    scp_link_if.device               link,
    // pins and loop status
    input  wire logic                power_down_pin_n_i,
    input  wire logic                if_tuning_i,
    input  wire logic                rf_tuning_i,
    input  wire logic                if_near_limit_i,
    input  wire logic                rf_near_limit_i,
    // section controls
    output logic                     if_section_on_o,
    output logic                     rf_section_on_o,
    output logic                     ref_amp_on_o,
    output logic                     if_low_power_o,
    output logic                     ref_input_halve_o,
    output logic [1:0]               if_output_divide_o,
    output logic                     rf_band_lower_o,
    output logic                     aux_output_pin_o,
    // loop settings
    output logic [1:0]               if_gain_code_o,
    output logic [1:0]               lower_band_gain_code_o,
    output logic [1:0]               upper_band_gain_code_o,
    output logic [UB_FB_W-1:0]       upper_band_feedback_count_o,
    output logic [LB_FB_W-1:0]       lower_band_feedback_count_o,
    output logic [IF_FB_W-1:0]       if_feedback_count_o,
    output logic [REF_W-1:0]         upper_band_reference_count_o,
    output logic [REF_W-1:0]         lower_band_reference_count_o,
    output logic [REF_W-1:0]         if_reference_count_o
);
    // ------------------------------------------------------------
    // serial receiver
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] shift_next;
    logic              sclk_reg;
    logic              sen_n_reg;
    logic [DATA_W-1:0] regs_reg [NUM_REGS];
    scp_band_t         band_reg;
    wire               sclk_rise  = link.sclk & ~sclk_reg;
    wire               frame_end  = link.sen_n & ~sen_n_reg;
    wire [ADDR_W-1:0]  wr_addr    = shift_reg[WORD_W-1:DATA_W];
    wire [DATA_W-1:0]  wr_data    = shift_reg[DATA_W-1:0];
    // out-of-range addresses are dropped so reserved writes do no harm
    wire               wr_en      = frame_end & (wr_addr <= ADDR_LAST);

    // a short frame commits whatever the last 22 shifted bits were
    assign shift_next = {shift_reg[WORD_W-2:0], link.sdata};

    // shifter has no power gating: writes land in any power state
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
            sclk_reg  <= 1'b0;
            sen_n_reg <= 1'b1;
        end else begin
            sclk_reg  <= link.sclk;
            sen_n_reg <= link.sen_n;
            if (!link.sen_n && sclk_rise) begin
                shift_reg <= shift_next;
            end
        end
    end

    // ------------------------------------------------------------
    // register bank, kept through power-down
    // ------------------------------------------------------------
    // cleared on reset so every output starts from a known value
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    regs_reg[gi] <= REG_RST;
                end else if (wr_en && wr_addr == ADDR_W'(gi)) begin
                    regs_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    wire wr_upper = wr_en & (wr_addr == ADDR_UB_FB || wr_addr == ADDR_UB_REF);
    wire wr_lower = wr_en & (wr_addr == ADDR_LB_FB || wr_addr == ADDR_LB_REF);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            band_reg <= SCP_BAND_UPPER;
        end else if (wr_upper) begin
            band_reg <= SCP_BAND_UPPER;
        end else if (wr_lower) begin
            band_reg <= SCP_BAND_LOWER;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire [DATA_W-1:0] main_cfg = regs_reg[ADDR_MAIN_CFG];
    wire [DATA_W-1:0] pwr_ctl  = regs_reg[ADDR_PWR_CTL];
    wire [DATA_W-1:0] gain     = regs_reg[ADDR_PD_GAIN];
    wire auto_all_on        = main_cfg[AUTO_ON_BIT];
    wire if_section_enable  = pwr_ctl[IF_EN_BIT];
    wire rf_section_enable  = pwr_ctl[RF_EN_BIT];
    wire [1:0] aux_pin_select = main_cfg[AUX_SEL_LSB +: 2];
    // pin low overrides all; pin high follows the enable or auto-on
    function automatic logic section_on(input logic pin_n,
                                        input logic auto_on,
                                        input logic enable);
        return pin_n & (auto_on | enable);
    endfunction

    wire if_on  = section_on(power_down_pin_n_i, auto_all_on,
                             if_section_enable);
    wire rf_on  = section_on(power_down_pin_n_i, auto_all_on,
                             rf_section_enable);
    // auto-on counts as setting both enables; pin low shuts the IF, RF and reference sections
    wire ref_on = section_on(power_down_pin_n_i, auto_all_on,
                             if_section_enable | rf_section_enable);
    wire lock_warning_n = if_tuning_i | rf_tuning_i
                        | if_near_limit_i | rf_near_limit_i;
    // reserved codes drive low, same as the force-low code
    wire aux_next = (aux_pin_select == AUX_LOCK_WARN) ? lock_warning_n : 1'b0;

    // ------------------------------------------------------------
    // registered power, band and aux outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            if_section_on_o  <= 1'b0;
            rf_section_on_o  <= 1'b0;
            ref_amp_on_o     <= 1'b0;
            rf_band_lower_o  <= 1'b0;
            aux_output_pin_o <= 1'b0;
        end else begin
            if_section_on_o  <= if_on;
            rf_section_on_o  <= rf_on;
            ref_amp_on_o     <= ref_on;
            rf_band_lower_o  <= (band_reg == SCP_BAND_LOWER);
            aux_output_pin_o <= aux_next;
        end
    end

    // ------------------------------------------------------------
    // registered configuration outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            if_low_power_o         <= 1'b0;
            ref_input_halve_o      <= 1'b0;
            if_output_divide_o     <= 2'h0;
            if_gain_code_o         <= 2'h0;
            lower_band_gain_code_o <= 2'h0;
            upper_band_gain_code_o <= 2'h0;
        end else begin
            if_low_power_o         <= main_cfg[IF_LOWP_BIT];
            ref_input_halve_o      <= main_cfg[REF_HALVE_BIT];
            if_output_divide_o     <= main_cfg[IF_DIV_LSB +: 2];
            if_gain_code_o         <= gain[IF_GAIN_LSB +: 2];
            lower_band_gain_code_o <= gain[LB_GAIN_LSB +: 2];
            upper_band_gain_code_o <= gain[UB_GAIN_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // registered divider counts
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upper_band_feedback_count_o  <= '0;
            lower_band_feedback_count_o  <= '0;
            if_feedback_count_o          <= '0;
            upper_band_reference_count_o <= '0;
            lower_band_reference_count_o <= '0;
            if_reference_count_o         <= '0;
        end else begin
            upper_band_feedback_count_o  <= regs_reg[ADDR_UB_FB][UB_FB_W-1:0];
            lower_band_feedback_count_o  <= regs_reg[ADDR_LB_FB][LB_FB_W-1:0];
            if_feedback_count_o          <= regs_reg[ADDR_IF_FB][IF_FB_W-1:0];
            upper_band_reference_count_o <= regs_reg[ADDR_UB_REF][REF_W-1:0];
            lower_band_reference_count_o <= regs_reg[ADDR_LB_REF][REF_W-1:0];
            if_reference_count_o         <= regs_reg[ADDR_IF_REF][REF_W-1:0];
        end
    end
endmodule // scp_device

// file: hw/scp_host.sv
// host end: serialises register writes onto the three-wire link
`timescale 1ns/1ns
module scp_host
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    // write request
    input  wire logic                wr_valid_i,
    input  wire logic [ADDR_W-1:0]   wr_addr_i,
    input  wire logic [DATA_W-1:0]   wr_data_i,
    output logic                     wr_ready_o,
    output logic                     wr_done_o,
    // link
    scp_link_if.host                 link
);
    typedef enum logic [1:0] { SCP_IDLE, SCP_SHIFT, SCP_END } scp_host_state_t;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    scp_host_state_t   state_reg;
    logic [WORD_W-1:0] word_reg;
    logic [4:0]        bit_cnt_reg;
    logic [3:0]        div_reg;
    logic              phase_reg;
    logic              sclk_reg;
    logic              sen_n_reg;
    wire               tick = (div_reg == SCLK_DIV - 4'h1);
    // reserved addresses are refused outright
    wire               legal = (wr_addr_i <= ADDR_LAST);
    // data goes out unmasked: the caller keeps unused bits zero
    wire [DATA_W-1:0]  clean = wr_data_i;

    assign link.sclk  = sclk_reg;
    assign link.sdata = word_reg[WORD_W-1];
    assign link.sen_n = sen_n_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= SCP_IDLE;
            word_reg    <= '0;
            bit_cnt_reg <= SHIFT_CNT_RST;
            div_reg     <= 4'h0;
            phase_reg   <= 1'b0;
            sclk_reg    <= 1'b0;
            sen_n_reg   <= 1'b1;
            wr_ready_o  <= 1'b0;
            wr_done_o   <= 1'b0;
        end else begin
            div_reg   <= tick ? 4'h0 : div_reg + 4'h1;
            wr_done_o <= 1'b0;
            case (state_reg)
                SCP_IDLE: begin
                    wr_ready_o <= 1'b1;
                    if (wr_valid_i && wr_ready_o && legal) begin
                        word_reg    <= {wr_addr_i, clean};
                        bit_cnt_reg <= SHIFT_CNT_RST;
                        phase_reg   <= 1'b0;
                        sen_n_reg   <= 1'b0;
                        wr_ready_o  <= 1'b0;
                        state_reg   <= SCP_SHIFT;
                    end
                end
                SCP_SHIFT: begin
                    if (tick) begin
                        phase_reg <= ~phase_reg;
                        sclk_reg  <= ~phase_reg;
                        if (phase_reg) begin
                            word_reg    <= {word_reg[WORD_W-2:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == 5'(WORD_W - 1)) begin
                                state_reg <= SCP_END;
                            end
                        end
                    end
                end
                SCP_END: begin
                    if (tick) begin
                        sen_n_reg <= 1'b1;
                        wr_done_o <= 1'b1;
                        state_reg <= SCP_IDLE;
                    end
                end
                default: state_reg <= SCP_IDLE;
            endcase
        end
    end
endmodule // scp_host

// file: hw/scp_link_if.sv
// three-wire serial link between host and synthesizer control
`timescale 1ns/1ns
interface scp_link_if;
    logic sclk;
    logic sdata;
    logic sen_n;
    modport host   (output sclk, output sdata, output sen_n);
    modport device (input sclk, input sdata, input sen_n);
endinterface

// file: hw/scp_pkg.sv
// shared constants and types for the synthesizer control block
package scp_pkg;
    // ------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 18;
    localparam int WORD_W = ADDR_W + DATA_W;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_MAIN_CFG  = 4'h0;
    localparam logic [3:0] ADDR_PD_GAIN   = 4'h1;
    localparam logic [3:0] ADDR_PWR_CTL   = 4'h2;
    localparam logic [3:0] ADDR_UB_FB     = 4'h3;
    localparam logic [3:0] ADDR_LB_FB     = 4'h4;
    localparam logic [3:0] ADDR_IF_FB     = 4'h5;
    localparam logic [3:0] ADDR_UB_REF    = 4'h6;
    localparam logic [3:0] ADDR_LB_REF    = 4'h7;
    localparam logic [3:0] ADDR_IF_REF    = 4'h8;
    localparam logic [3:0] ADDR_LAST      = 4'h8;
    localparam int NUM_REGS = 9;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AUX_SEL_LSB   = 12;
    localparam int IF_DIV_LSB    = 10;
    localparam int REF_HALVE_BIT = 6;
    localparam int IF_LOWP_BIT   = 5;
    localparam int AUTO_ON_BIT   = 3;
    localparam int IF_GAIN_LSB   = 4;
    localparam int LB_GAIN_LSB   = 2;
    localparam int UB_GAIN_LSB   = 0;
    localparam int IF_EN_BIT     = 1;
    localparam int RF_EN_BIT     = 0;
    localparam int UB_FB_W       = 18;
    localparam int LB_FB_W       = 17;
    localparam int IF_FB_W       = 16;
    localparam int REF_W         = 13;
    // ------------------------------------------------------------
    // aux select codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  AUX_FORCE_LOW = 2'h1;
    localparam logic [1:0]  AUX_LOCK_WARN = 2'h3;
    localparam logic [17:0] REG_RST       = 18'h00000;
    localparam logic [4:0]  SHIFT_CNT_RST = 5'h00;
    // serial clock: one enable pulse every SCLK_DIV mclk cycles
    localparam logic [3:0]  SCLK_DIV      = 4'h4;
    typedef enum logic { SCP_BAND_UPPER, SCP_BAND_LOWER } scp_band_t;
endpackage

// file: verif/scp_assertions.sv
// link framing and power gating assertions for the synthesizer control block
`timescale 1ns/1ns
module scp_assertions (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // link
    input  wire logic sclk_i,
    input  wire logic sdata_i,
    input  wire logic sen_n_i,
    // pin and power outputs
    input  wire logic power_down_pin_n_i,
    input  wire logic if_section_on_i,
    input  wire logic rf_section_on_i,
    input  wire logic ref_amp_on_i
);
    logic       sclk_q_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    // counts clock rises the way the device samples them: low last cycle, high now
    assign bit_cnt_next = sen_n_i ? 5'h00 : bit_cnt_reg + {4'h0, sclk_i & ~sclk_q_reg};
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q_reg  <= 1'b0;
            bit_cnt_reg <= 5'h00;
        end else begin
            sclk_q_reg  <= sclk_i;
            bit_cnt_reg <= bit_cnt_next;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence sclk_high_s;
        sclk_i [*4] ##1 !sclk_i;
    endsequence
    sequence sclk_low_s;
        !sclk_i [*4];
    endsequence
    pin_low_off_a: assert property (
        !power_down_pin_n_i |=> !if_section_on_i && !rf_section_on_i && !ref_amp_on_i)
        else $error("sections on while power-down pin low");
    ref_amp_a: assert property (
        ref_amp_on_i == (if_section_on_i || rf_section_on_i))
        else $error("reference amplifier state wrong");
    idle_clock_a: assert property (sen_n_i |-> !sclk_i)
        else $error("serial clock moves outside a frame");
    data_stable_a: assert property (sclk_i && $past(sclk_i) |-> $stable(sdata_i))
        else $error("serial data changed while clock high");
    frame_bits_a: assert property ($rose(sen_n_i) |-> bit_cnt_reg == 5'h16)
        else $error("frame did not carry 22 bits");
    frame_span_a: assert property ($fell(sen_n_i) |-> ##[150:210] $rose(sen_n_i))
        else $error("frame length out of range");
    sclk_high_a: assert property ($rose(sclk_i) |-> sclk_high_s)
        else $error("serial clock high phase wrong");
    sclk_low_a: assert property ($fell(sclk_i) |-> sclk_low_s)
        else $error("serial clock low phase too short");
endmodule // scp_assertions

// file: verif/testbench.sv
// self-checking bench: host and device joined over the serial link
`timescale 1ns/1ns
module testbench;
    import scp_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr_valid = 1'b0;
    logic [3:0]  wr_addr = 4'h0;
    logic [17:0] wr_data = 18'h00000;
    logic        pin_n = 1'b1;
    logic [3:0]  stat = 4'h0;
    logic        wr_ready, wr_done, if_on, rf_on, ref_on, lowp, halve, band_lo, aux;
    logic [1:0]  if_output_divide, g_if, g_lb, g_ub;
    logic [17:0] ub_fb;
    logic [16:0] lb_fb;
    logic [15:0] if_fb;
    logic [12:0] ub_ref, lb_ref, if_ref;
    int          n_mismatch = 0;
    int          checks_done = 0;
    always #5 mclk = ~mclk;
    scp_link_if link ();
    scp_host scp_host_i (.mclk_i(mclk), .rst_n_i(rst_n), .wr_valid_i(wr_valid),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
        .wr_done_o(wr_done), .link(link));
    scp_device scp_device_i (.mclk_i(mclk), .rst_n_i(rst_n), .link(link),
        .power_down_pin_n_i(pin_n), .if_tuning_i(stat[0]), .rf_tuning_i(stat[1]),
        .if_near_limit_i(stat[2]), .rf_near_limit_i(stat[3]), .if_section_on_o(if_on),
        .rf_section_on_o(rf_on), .ref_amp_on_o(ref_on), .if_low_power_o(lowp),
        .ref_input_halve_o(halve), .if_output_divide_o(if_output_divide), .rf_band_lower_o(band_lo),
        .aux_output_pin_o(aux), .if_gain_code_o(g_if), .lower_band_gain_code_o(g_lb),
        .upper_band_gain_code_o(g_ub), .upper_band_feedback_count_o(ub_fb),
        .lower_band_feedback_count_o(lb_fb), .if_feedback_count_o(if_fb),
        .upper_band_reference_count_o(ub_ref), .lower_band_reference_count_o(lb_ref),
        .if_reference_count_o(if_ref));
    scp_assertions scp_assertions_i (.mclk_i(mclk), .rst_n_i(rst_n), .sclk_i(link.sclk),
        .sdata_i(link.sdata), .sen_n_i(link.sen_n), .power_down_pin_n_i(pin_n),
        .if_section_on_i(if_on), .rf_section_on_i(rf_on), .ref_amp_on_i(ref_on));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ready is sampled at the falling edge so the taking edge is never raced
    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wr_valid <= 1'b1;
        wr_addr  <= a;
        wr_data  <= d;
        @(negedge mclk);
        while (wr_ready !== 1'b1 && n++ < 50) @(negedge mclk);
        chk("wr_ready", 18'h1, {17'h0, wr_ready});
        @(posedge mclk);
        wr_valid <= 1'b0;
        n = 0;
        while (wr_done !== 1'b1 && n++ < 400) @(negedge mclk);
        chk("wr_done", 18'h1, {17'h0, wr_done});
        repeat (3) @(negedge mclk);
    endtask
    task automatic set_in(input logic p, input logic [3:0] s);
        @(posedge mclk);
        pin_n <= p;
        stat  <= s;
        repeat (2) @(negedge mclk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int d = 0; d < 4; d++) begin
            wr(ADDR_MAIN_CFG, 18'h01060 | (18'(d) << IF_DIV_LSB));
            chk("if_div", 18'(d), 18'(if_output_divide));
            chk("halve_lowp_aux", 18'h6, {15'h0, halve, lowp, aux});
        end
        wr(ADDR_PD_GAIN, 18'h0001B);
        wr(ADDR_UB_FB, 18'h2AAAA);
        wr(ADDR_LB_FB, 18'h15555);
        wr(ADDR_IF_FB, 18'h0A5A5);
        wr(ADDR_UB_REF, 18'h01ABC);
        wr(ADDR_LB_REF, 18'h00F0F);
        wr(ADDR_IF_REF, 18'h01234);
        chk("gains", 18'h1B, {12'h0, g_if, g_lb, g_ub});
        chk("ub_fb", 18'h2AAAA, ub_fb);
        chk("lb_fb", 18'h15555, 18'(lb_fb));
        chk("if_fb", 18'h0A5A5, 18'(if_fb));
        chk("ub_ref", 18'h01ABC, 18'(ub_ref));
        chk("lb_ref", 18'h00F0F, 18'(lb_ref));
        chk("if_ref", 18'h01234, 18'(if_ref));
        $display("test regs done");
    endtask
    task automatic t_band;
        logic [3:0] a [6] = '{ADDR_LB_FB, ADDR_IF_FB, ADDR_UB_REF, ADDR_LB_REF,
                              ADDR_IF_REF, ADDR_UB_FB};
        logic       e [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            wr(a[i], 18'h00400);
            chk("band_lower", {17'h0, e[i]}, {17'h0, band_lo});
        end
        $display("test band done");
    endtask
    // writes land while the pin holds everything off, then take effect on release
    task automatic t_power;
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            set_in(1'b0, 4'h0);
            wr(ADDR_MAIN_CFG, {14'h0, m[2], 3'h0});
            wr(ADDR_PWR_CTL, {16'h0, m[1:0]});
            chk("pin_low_pwr", 18'h0, {15'h0, if_on, rf_on, ref_on});
            set_in(1'b1, 4'h0);
            chk("pin_high_pwr", {15'h0, m[2] | m[1], m[2] | m[0], |m},
                {15'h0, if_on, rf_on, ref_on});
        end
        chk("gains_kept", 18'h1B, {12'h0, g_if, g_lb, g_ub});
        $display("test power done");
    endtask
    task automatic t_aux;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MAIN_CFG, 18'(c) << AUX_SEL_LSB);
            for (int s = 0; s < 16; s++) begin
                set_in(1'b1, 4'(s));
                chk("aux", {17'h0, c == 3 && s != 0}, {17'h0, aux});
            end
        end
        chk("lowp_clear", 18'h0, {17'h0, lowp});
        // the host answers a warning by retuning, which clears the loop status
        set_in(1'b1, 4'h0);
        $display("test aux done");
    endtask
    // a mid-run reset clears the bank and sends the band back to upper
    task automatic t_rst;
        wr(ADDR_LB_FB, 18'h00400);
        chk("band_before_rst", 18'h1, {17'h0, band_lo});
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk("ready_in_rst", 18'h0, {17'h0, wr_ready});
        @(negedge mclk);
        chk("ready_after_rst", 18'h1, {17'h0, wr_ready});
        chk("pwr_after_rst", 18'h0, {15'h0, if_on, rf_on, ref_on});
        chk("cfg_after_rst", 18'h0, {11'h0, band_lo, g_if, g_lb, g_ub});
        $display("test reset done");
    endtask
    task automatic t_resv;
        for (int j = 0; j < 2; j++) begin
            @(posedge mclk);
            wr_valid <= 1'b1;
            wr_addr  <= 4'(9 + 6 * j);
            for (int k = 0; k < 20; k++) begin
                @(negedge mclk);
                chk("resv_ready_idle", 18'h3, {16'h0, wr_ready, link.sen_n});
            end
            @(posedge mclk);
            wr_valid <= 1'b0;
        end
        $display("test reserved done");
    endtask
    // ------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs;
        t_band;
        t_power;
        t_aux;
        t_rst;
        t_resv;
        test_done;
    end
    // about 40 writes of under 200 cycles each; generous margin on top
    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end
endmodule // testbench
